// ---- design/audio_status_params.svh ----
// Offsets and field positions of the audio control and link status registers,
// and the audio control reset value. Assumes the I2C slave presents byte-wide accesses.
//
// What this block does
// - Control bit 7 enables the TDM-to-parallel audio converter.
// - While converting, the converter's clock carries audio downstream.
// - Control bit 6 drives recovered input-stream audio onto the audio pins.
// - Audio pin output enable ignored unless source selection reads 0.
// - Control bit 3: audio type change resets the received audio FIFO.
// - Control bit 2: audio infoframe checksum change resets the FIFO.
// - Control bit 1: video infoframe checksum change resets the FIFO.
// - Control bit 0: clock regeneration N or CTS change resets the FIFO.
// - Status bit 7 reads 1 once downstream link is detected and qualified.
// - Status bit 6 reads 1 when transmitter active and receiver locked.
// - Transmitter bit set only after valid input and correct port mode.
// - With transmitter bit set, bits 5:4 report 01 for single link port 0.
// - Status bit 3 reads 1 while valid TMDS data is being recovered.
// - Status bit 2 reads 1 when input PLL is locked.
// - Status bit 1 reads 1 when no clock above the low threshold is found.
// - Status bit 0 reads 1 when input clock frequency is stable and status bit 1 reads 0.
// - Source selection 0 sends input-stream audio, 1 sends local pin audio.
// - Low-frequency threshold in MHz judges whether input clock is too low.
`ifndef AUDIO_STATUS_PARAMS_SVH
`define AUDIO_STATUS_PARAMS_SVH

`define AUDIO_CONTROL_OFFSET     8'h55
`define LINK_INPUT_STATUS_OFFSET 8'h5A
`define AUDIO_CONTROL_RESET      8'h0C
`define AUDIO_CONTROL_WMASK      8'hCF
`define TDM_TO_PARALLEL_BIT      7
`define INPUT_AUDIO_OUT_BIT      6
`define RST_ON_TYPE_BIT          3
`define RST_ON_AUDIO_IF_BIT      2
`define RST_ON_VIDEO_IF_BIT      1
`define RST_ON_CLOCK_REGEN_BIT   0
`define PORT_MODE_SINGLE_P0      2'h1
`define PORT_MODE_NONE           2'h0
`define SOURCE_INPUT_STREAM      1'h0
`define FIFO_RESET_CYCLES        4'h4

`endif

// ---- design/audio_status_pkg.sv ----
// Types shared by the audio control and link status register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package audio_status_pkg;

    typedef struct packed {
        logic tdm_to_parallel;
        logic input_audio_out;
        logic [1:0] reserved;
        logic fifo_reset_on_type;
        logic fifo_reset_on_audio_infoframe;
        logic fifo_reset_on_video_infoframe;
        logic fifo_reset_on_clock_regen;
    } audio_control_t;

    typedef struct packed {
        logic type_changed;
        logic audio_infoframe_changed;
        logic video_infoframe_changed;
        logic clock_regen_changed;
    } audio_events_t;

    typedef struct packed {
        logic downstream_link_ready;
        logic serial_tx_locked;
        logic [1:0] serial_port_mode;
        logic tmds_data_good;
        logic input_pll_locked;
        logic no_input_clock;
        logic input_frequency_settled;
    } link_input_status_t;

    typedef enum logic [1:0] {
        FIFO_IDLE  = 2'b01,
        FIFO_RESET = 2'b10
    } fifo_state_t;

endpackage

// ---- design/clock_low_detect.sv ----
// Compares a measured input clock frequency against the low threshold.
// Assumes the measurement and threshold are both whole MHz, held steady.
`timescale 1ns/1ps
`default_nettype none
module clock_low_detect #(
    parameter int FREQ_WIDTH = 8
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic [FREQ_WIDTH-1:0] measured_mhz,
    input  wire logic                  measure_valid,
    input  wire logic [5:0]            min_clock_threshold,
    output logic                       clock_too_low
);
    logic next_clock_too_low;

    // No valid measurement counts as no clock at all
    always_comb begin
        next_clock_too_low = !measure_valid ||
            (measured_mhz <= {{(FREQ_WIDTH-6){1'b0}}, min_clock_threshold});
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            clock_too_low <= 1'b1;
        end else begin
            clock_too_low <= next_clock_too_low;
        end
    end
endmodule
`default_nettype wire

// ---- design/audio_link_regs.sv ----
// Audio control and link status register bank of the bridge serializer.
// Assumes the I2C slave hands over one byte access per reg_wr/reg_rd pulse.
`include "audio_status_params.svh"
`timescale 1ns/1ps
`default_nettype none
module audio_link_regs
    import audio_status_pkg::*;
#(
    parameter int FREQ_WIDTH = 8
) (
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    // Register access from the control bus slave
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    output logic [7:0]                 reg_rdata,
    output logic                       reg_hit,
    // Settings held by neighbouring registers
    input  wire logic                  audio_source_local,
    input  wire logic [5:0]            min_clock_threshold,
    // Audio paths
    input  wire audio_events_t         audio_events,
    input  wire logic                  tdm_conv_clk,
    input  wire logic                  i2s_bit_clk,
    input  wire logic                  recovered_i2s_data,
    input  wire logic                  local_i2s_data,
    output logic                       tdm_conv_enable,
    output logic                       downstream_audio_clk_sel_tdm,
    output logic                       downstream_audio_data,
    output logic                       i2s_pin_data,
    output logic                       i2s_pin_oe,
    output logic                       audio_fifo_reset,
    // Live link and input conditions
    input  wire logic                  link_detected,
    input  wire logic                  link_caps_known,
    input  wire logic                  tx_active,
    input  wire logic                  remote_locked,
    input  wire logic                  single_mode_entered,
    input  wire logic                  tmds_data_good,
    input  wire logic                  input_pll_locked,
    input  wire logic [FREQ_WIDTH-1:0] measured_mhz,
    input  wire logic                  measure_valid,
    input  wire logic                  input_frequency_settled,
    output link_input_status_t         status
);
    // =========================================================
    // Audio control register
    audio_control_t audio_control;
    audio_control_t next_audio_control;

    always_comb begin
        next_audio_control = audio_control;
        if (reg_wr && reg_addr == `AUDIO_CONTROL_OFFSET) begin
            next_audio_control = reg_wdata & `AUDIO_CONTROL_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            audio_control <= `AUDIO_CONTROL_RESET;
        end else begin
            audio_control <= next_audio_control;
        end
    end

    // =========================================================
    // Audio routing
    logic input_source;
    logic next_i2s_pin_data;
    logic next_i2s_pin_oe;
    logic next_downstream_data;

    assign input_source = (audio_source_local == `SOURCE_INPUT_STREAM);
    assign tdm_conv_enable = audio_control.tdm_to_parallel;
    assign downstream_audio_clk_sel_tdm =
        audio_control.tdm_to_parallel;

    always_comb begin
        // Pin output only when the pins are not the audio source
        next_i2s_pin_oe = audio_control.input_audio_out
            && input_source;
        next_i2s_pin_data = next_i2s_pin_oe ? recovered_i2s_data : 1'b0;
        next_downstream_data = input_source ? recovered_i2s_data
                                            : local_i2s_data;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            i2s_pin_oe   <= 1'b0;
            i2s_pin_data <= 1'b0;
        end else begin
            i2s_pin_oe   <= next_i2s_pin_oe;
            i2s_pin_data <= next_i2s_pin_data;
        end
    end

    // Downstream data launched on the selected audio clock domain proxy
    logic selected_clk;
    logic selected_clk_d;
    logic next_selected_clk_d;
    logic next_downstream_audio_data;

    assign selected_clk = audio_control.tdm_to_parallel ? tdm_conv_clk
                                                        : i2s_bit_clk;
    always_comb begin
        next_selected_clk_d = selected_clk;
        next_downstream_audio_data = downstream_audio_data;
        if (selected_clk && !selected_clk_d) begin
            next_downstream_audio_data = next_downstream_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            selected_clk_d        <= 1'b0;
            downstream_audio_data <= 1'b0;
        end else begin
            selected_clk_d        <= next_selected_clk_d;
            downstream_audio_data <= next_downstream_audio_data;
        end
    end

    // =========================================================
    // Received audio FIFO reset control
    fifo_state_t fifo_state;
    fifo_state_t next_fifo_state;
    logic [3:0]  fifo_count;
    logic [3:0]  next_fifo_count;
    logic        fifo_trigger;

    always_comb begin
        fifo_trigger =
            (audio_control.fifo_reset_on_type
                && audio_events.type_changed) ||
            (audio_control.fifo_reset_on_audio_infoframe
                && audio_events.audio_infoframe_changed) ||
            (audio_control.fifo_reset_on_video_infoframe
                && audio_events.video_infoframe_changed) ||
            (audio_control.fifo_reset_on_clock_regen
                && audio_events.clock_regen_changed);
    end

    // A fresh trigger restarts the pulse so the FIFO sees a full reset
    always_comb begin
        next_fifo_state = fifo_state;
        next_fifo_count = fifo_count;
        case (fifo_state)
            FIFO_IDLE: begin
                if (fifo_trigger) begin
                    next_fifo_state = FIFO_RESET;
                    next_fifo_count = `FIFO_RESET_CYCLES - 4'h1;
                end
            end
            FIFO_RESET: begin
                if (fifo_trigger) begin
                    next_fifo_count = `FIFO_RESET_CYCLES - 4'h1;
                end else if (fifo_count == 4'h0) begin
                    next_fifo_state = FIFO_IDLE;
                end else begin
                    next_fifo_count = fifo_count - 4'h1;
                end
            end
            default: begin
                next_fifo_state = FIFO_IDLE;
                next_fifo_count = 4'h0;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fifo_state <= FIFO_IDLE;
            fifo_count <= 4'h0;
        end else begin
            fifo_state <= next_fifo_state;
            fifo_count <= next_fifo_count;
        end
    end

    assign audio_fifo_reset = (fifo_state == FIFO_RESET);

    // =========================================================
    // Link and input status
    logic               clock_too_low;
    link_input_status_t next_status;

    clock_low_detect #(
        .FREQ_WIDTH (FREQ_WIDTH)
    ) u_clock_low_detect (
        .core_clk            (core_clk),
        .reset               (reset),
        .measured_mhz        (measured_mhz),
        .measure_valid       (measure_valid),
        .min_clock_threshold (min_clock_threshold),
        .clock_too_low       (clock_too_low)
    );

    always_comb begin
        next_status = '0;
        next_status.downstream_link_ready =
            link_detected && link_caps_known;
        // Locked only once the input is valid and single mode is entered
        next_status.serial_tx_locked = tx_active && remote_locked
            && tmds_data_good && single_mode_entered;
        next_status.serial_port_mode = next_status.serial_tx_locked
            ? `PORT_MODE_SINGLE_P0 : `PORT_MODE_NONE;
        next_status.tmds_data_good = tmds_data_good;
        next_status.input_pll_locked = input_pll_locked;
        next_status.no_input_clock = clock_too_low;
        next_status.input_frequency_settled =
            input_frequency_settled && !clock_too_low;
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    // =========================================================
    // Read path; status writes fall through untouched
    logic [7:0] next_reg_rdata;

    always_comb begin
        next_reg_rdata = reg_rdata;
        reg_hit = (reg_addr == `AUDIO_CONTROL_OFFSET) ||
                  (reg_addr == `LINK_INPUT_STATUS_OFFSET);
        if (reg_rd) begin
            case (reg_addr)
                `AUDIO_CONTROL_OFFSET:     next_reg_rdata = audio_control;
                `LINK_INPUT_STATUS_OFFSET: next_reg_rdata = status;
                default:                   next_reg_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_reg_rdata;
        end
    end
endmodule
`default_nettype wire

// ---- dv/audio_link_regs_monitor.sv ----
// Checker for the audio control and link status register bank.
// Assumes it is bound to audio_link_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module audio_link_regs_monitor
    import audio_status_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               reset,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [7:0]         reg_addr,
    input wire logic [7:0]         reg_wdata,
    input wire logic [7:0]         reg_rdata,
    input wire logic               audio_source_local,
    input wire audio_events_t      audio_events,
    input wire logic               tdm_conv_enable,
    input wire logic               downstream_audio_clk_sel_tdm,
    input wire logic               i2s_pin_oe,
    input wire logic               audio_fifo_reset,
    input wire logic               input_pll_locked,
    input wire link_input_status_t status
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // ====================
    // Properties
    tdm_enable_a: assert property (
        reg_wr && reg_addr == 8'h55 |=> tdm_conv_enable == $past(reg_wdata[7]))
        else $error("converter enable does not follow write");
    clock_select_a: assert property (
        reg_wr && reg_addr == 8'h55 |=>
            downstream_audio_clk_sel_tdm == $past(reg_wdata[7]))
        else $error("audio clock select does not follow write");
    pin_oe_a: assert property (
        i2s_pin_oe |-> !$past(audio_source_local))
        else $error("pin output enabled with local source");
    fifo_cause_a: assert property (
        $rose(audio_fifo_reset) |-> |$past(audio_events))
        else $error("fifo reset without event");
    fifo_width_a: assert property (
        $rose(audio_fifo_reset) |-> audio_fifo_reset [*4])
        else $error("fifo reset shorter than four cycles");
    port_mode_a: assert property (
        status.serial_port_mode == {1'b0, status.serial_tx_locked})
        else $error("port mode does not match transmitter bit");
    settled_a: assert property (
        status.input_frequency_settled |-> !status.no_input_clock)
        else $error("settled while clock missing");
    pll_lock_a: assert property (
        !$past(reset) |-> status.input_pll_locked == $past(input_pll_locked))
        else $error("pll lock bit stale");
    status_read_a: assert property (
        reg_rd && reg_addr == 8'h5A |=> reg_rdata == $past(status))
        else $error("status read differs from status image");
    cover property ($rose(audio_fifo_reset));
    cover property (status.serial_tx_locked);
    cover property (reg_rd && reg_addr == 8'h5A);
endmodule
bind audio_link_regs audio_link_regs_monitor mon (.*);
`default_nettype wire

// ---- dv/ctl_model.sv ----
// Control bus master standing in for the serial controller.
// Assumes one strobe per byte access, taken on a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ctl_model (
    input  wire logic core_clk,
    output logic      reg_wr,
    output logic      reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    // ====================
    // One-cycle strobe; released lines show inverted data
    task automatic access(input logic w, input logic [7:0] a, v);
        @(negedge core_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, v};
        @(negedge core_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h0, ~a, ~v};
    endtask
endmodule
`default_nettype wire

// ---- dv/audio_link_regs_tb_top.sv ----
// Testbench for the audio control and link status register bank.
// Assumes the bank and its checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module audio_link_regs_tb_top;
    import audio_status_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, audio_source_local = 1'b0;
    logic tdm_conv_clk = 1'b0, i2s_bit_clk = 1'b0;
    logic recovered_i2s_data = 1'b0, local_i2s_data = 1'b0;
    logic reg_wr, reg_rd, reg_hit, rd_q, tdm_conv_enable;
    logic downstream_audio_clk_sel_tdm, downstream_audio_data;
    logic i2s_pin_data, i2s_pin_oe, audio_fifo_reset;
    logic link_detected, link_caps_known, tx_active, remote_locked;
    logic single_mode_entered, tmds_data_good, input_pll_locked;
    logic measure_valid, input_frequency_settled;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, measured_mhz, d;
    logic [5:0] min_clock_threshold;
    logic [31:0] r;
    logic [7:0] expq[$];
    logic [7:0] ctl_m;
    logic clk_m, pin_m, ds_m, hit_q, hit_m;
    audio_events_t audio_events = '0;
    link_input_status_t status;
    int n_errors = 0, cmp_count = 0, seed = 32'hA3496D5E, i, j, k;

    audio_link_regs dut (.*);
    ctl_model ctl (.*);

    initial forever #2.5 core_clk = ~core_clk;
    always @(negedge core_clk)
        {tdm_conv_clk, i2s_bit_clk, recovered_i2s_data, local_i2s_data}
            <= 4'($random(seed));
    // ====================
    // Read results checked in issue order
    // Bench image of the audio routing, fed by the bus it drives itself
    always @(posedge core_clk) begin
        rd_q  <= reg_rd;
        hit_q <= reg_hit;
        hit_m <= reg_addr == 8'h55 || reg_addr == 8'h5A;
        if (reset) begin
            {ctl_m, clk_m, pin_m, ds_m} <= {8'h0C, 3'h0};
        end else begin
            if (reg_wr && reg_addr == 8'h55)
                ctl_m <= reg_wdata & 8'hCF;
            clk_m <= ctl_m[7] ? tdm_conv_clk : i2s_bit_clk;
            pin_m <= ctl_m[6] && !audio_source_local && recovered_i2s_data;
            if ((ctl_m[7] ? tdm_conv_clk : i2s_bit_clk) && !clk_m)
                ds_m <= audio_source_local ? local_i2s_data
                                           : recovered_i2s_data;
        end
    end
    always @(negedge core_clk) if (!reset)
        chk({5'h0, hit_q, i2s_pin_data, downstream_audio_data},
            {5'h0, hit_m, pin_m, ds_m});
    always @(negedge core_clk) if (rd_q === 1'b1)
        chk(reg_rdata, expq.pop_front());

    task automatic chk(input logic [7:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        ctl.access(1'b1, a, v);
    endtask
    task automatic rd(input logic [7:0] a, exp);
        expq.push_back(exp);
        ctl.access(1'b0, a, 8'h00);
    endtask
    task automatic set_live(input logic [31:0] v);
        {link_detected, link_caps_known, tx_active, remote_locked} = v[6:3];
        {single_mode_entered, tmds_data_good, input_pll_locked} = v[2:0];
        {measure_valid, input_frequency_settled} = v[23:22];
        measured_mhz = v[15:8];
        min_clock_threshold = v[21:16];
    endtask
    function automatic logic [7:0] exp_status();
        logic lo, tx;
        lo = !measure_valid || measured_mhz <= {2'h0, min_clock_threshold};
        tx = tx_active & remote_locked & single_mode_entered & tmds_data_good;
        return {link_detected & link_caps_known, tx, 1'b0, tx, tmds_data_good,
                input_pll_locked, lo, input_frequency_settled & !lo};
    endfunction
    task automatic report_and_stop();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // ====================
    // Scenarios
    initial begin
        set_live(32'h0);
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        rd(8'h55, 8'h0C);
        rd(8'h33, 8'h00);
        $display("reset values done");
        for (i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            audio_source_local = i[0];
            wr(8'h55, d);
            rd(8'h55, d & 8'hCF);
            chk({5'h0, tdm_conv_enable, downstream_audio_clk_sel_tdm,
                 i2s_pin_oe}, {5'h0, d[7], d[7], d[6] & !i[0]});
        end
        $display("audio control done");
        for (i = 0; i < 4; i++) for (j = 0; j < 4; j++) begin
            wr(8'h55, 8'h01 << i);
            @(negedge core_clk) audio_events = audio_events_t'(4'h1 << j);
            for (k = 0; k < 5; k++) begin
                @(negedge core_clk) audio_events = '0;
                chk({7'h0, audio_fifo_reset}, {7'h0, i == j && k < 4});
            end
        end
        $display("fifo reset done");
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            if (i == 0) r[22:8] = {1'b1, r[21:16], 2'h0, r[21:16]};
            set_live(r);
            wr(8'h5A, r[31:24]);
            rd(8'h5A, exp_status());
        end
        $display("status done");
        report_and_stop();
    end
    initial begin
        #50000;
        n_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
